// file: dv/dmb_properties.sv
// Checker for the handshakes on the link between the two ends
`timescale 1ns/1ns
`default_nettype none
module dmb_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        m2d_tog,
  input wire logic [7:0]  m2d_ctrl,
  input wire logic [15:0] m2d_data,
  input wire logic        m2d_ack,
  input wire logic        d2m_tog,
  input wire logic [7:0]  d2m_ctrl,
  input wire logic [15:0] d2m_data,
  input wire logic        d2m_ack
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_m2d_set_held: assert property (
    (m2d_tog != m2d_ack) ##1 (m2d_tog != m2d_ack) |-> $stable(m2d_ctrl) && $stable(m2d_data))
    else $error("outbound set changed while pending");
  chk_d2m_set_held: assert property (
    (d2m_tog != d2m_ack) ##1 (d2m_tog != d2m_ack) |-> $stable(d2m_ctrl) && $stable(d2m_data))
    else $error("inbound set changed while pending");
  chk_m2d_sync_delay: assert property (
    $changed(m2d_tog) |-> (m2d_ack != m2d_tog) [*3])
    else $error("outbound ack too early");
  chk_d2m_sync_delay: assert property (
    $changed(d2m_tog) |-> (d2m_ack != d2m_tog) [*3])
    else $error("inbound ack too early");
  chk_m2d_ack_match: assert property (
    $changed(m2d_ack) |-> m2d_ack == m2d_tog)
    else $error("outbound ack without request");
  chk_d2m_ack_match: assert property (
    $changed(d2m_ack) |-> d2m_ack == d2m_tog)
    else $error("inbound ack without request");
  chk_d2m_ack_bound: assert property (
    $changed(d2m_tog) |-> ##[3:12] (d2m_ack == d2m_tog))
    else $error("inbound set not taken in time");
  chk_m2d_no_retog: assert property (
    (m2d_tog != m2d_ack) |=> $stable(m2d_tog))
    else $error("outbound toggled while pending");
endmodule : dmb_properties
`default_nettype wire

// file: dv/dsp_mcu_mailbox_irq_tb.sv
// Testbench for the mailbox and interrupt block
`timescale 1ns/1ns
`default_nettype none
module dsp_mcu_mailbox_irq_tb;
  import dmb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_req, wake_req;
  logic        sample_frame_tick, dsp_on, io_rd, io_wr, timebase_evt;
  logic [31:0] haddr, hwdata, hrdata, v, r;
  logic [1:0]  htrans, io_addr;
  logic [4:0]  pin_level;
  logic [15:0] io_wdata, io_rdata;
  int          fail_count, n_compared, cyc, seed;
  logic [23:0] q[$];
  logic [7:0]  ix[5] = '{IDX_IEN_LOW, IDX_IEN_HIGH, IDX_WAKE_DIS, IDX_PIN_POL, IDX_INT_CTRL};
  logic [7:0]  mk[5] = '{8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h03};
  dmb_if lnk ();
  dmb_micro #(.MINUTE_CYCLES(50)) dmb_micro_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lnk(lnk.micro_end), .pin_level(pin_level), .src_pend(5'h00), .i2c_pend(1'b0),
    .timebase_evt(timebase_evt), .sample_frame_tick(sample_frame_tick), .irq_req(irq_req), .wake_req(wake_req));
  dmb_coproc dmb_coproc_inst (
    .hclk(hclk), .hresetn(hresetn), .lnk(lnk.coproc_end), .dsp_on(dsp_on), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata));
  dmb_properties dmb_properties_inst (
    .hclk(hclk), .hresetn(hresetn), .m2d_tog(lnk.m2d_tog), .m2d_ctrl(lnk.m2d_ctrl),
    .m2d_data(lnk.m2d_data), .m2d_ack(lnk.m2d_ack), .d2m_tog(lnk.d2m_tog), .d2m_ctrl(lnk.d2m_ctrl),
    .d2m_data(lnk.d2m_data), .d2m_ack(lnk.d2m_ack));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic ahb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, i, d, x);
  endtask : wr
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, i, 8'h00, x);
    cmp(x, e);
    cmp({31'h0, hresp}, 32'h0);
  endtask : rc
  task automatic io(input logic w, input logic [1:0] a, input logic [15:0] d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    @(posedge hclk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : io
  task automatic tick();
    sample_frame_tick <= 1'b1;
    @(posedge hclk);
    sample_frame_tick <= 1'b0;
    @(posedge hclk);
  endtask : tick
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, sample_frame_tick} = '0;
    {dsp_on, io_rd, io_wr, io_addr, io_wdata, timebase_evt} = '0;
    pin_level = 5'h1F;
    seed = 32'h05EFE470;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(IDX_IRQ_FLAGS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rc(ix[i], 32'h0);
      v = $random(seed);
      wr(ix[i], v[7:0]);
      rc(ix[i], {24'h0, v[7:0] & mk[i]});
      wr(ix[i], 8'h00);
    end
    wr(8'h20, 8'hFF);
    rc(8'h20, 32'h0);
    for (int k = 0; k < 3; k++) begin
      repeat (1250) @(posedge hclk);
      v = $random(seed);
      q.push_back(v[23:0]);
      dsp_on <= (k != 0);
      wr(IDX_OUT_B1, v[15:8]);
      wr(IDX_OUT_B2, v[7:0]);
      wr(IDX_OUT_B0, v[23:16]);
      repeat (20) @(posedge hclk);
      rc(IDX_MISC, (k == 0) ? 32'h10 : 32'h0);
      dsp_on <= 1'b1;
      repeat (20) @(posedge hclk);
      r = {8'h00, q.pop_front()};
      io(1'b0, IO_IN_CTRL, 16'h0);
      cmp({16'h0, io_rdata}, {24'h0, r[23:16]});
      io(1'b0, IO_IN_DATA, 16'h0);
      cmp({16'h0, io_rdata}, {16'h0, r[15:0]});
    end
    wr(IDX_IEN_HIGH, 8'h40);
    wr(IDX_IRQ_FLAGS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      repeat (1250) @(posedge hclk);
      wr(IDX_IEN_LOW, k ? 8'h00 : 8'h80);
      v = $random(seed);
      io(1'b1, IO_OUT_DATA, v[15:0]);
      io(1'b1, IO_OUT_CTRL, {8'h00, v[23:16]});
      repeat (20) @(posedge hclk);
      rc(IDX_IN_B0, {24'h0, v[23:16]});
      rc(IDX_IN_B1, {24'h0, v[15:8]});
      rc(IDX_IN_B2, {24'h0, v[7:0]});
      rc(IDX_IRQ_FLAGS, 32'h40);
      cmp({31'h0, irq_req}, {31'h0, !k[0]});
      wr(IDX_IRQ_FLAGS, 8'h00);
      rc(IDX_IRQ_FLAGS, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      wr(IDX_MISC, {7'h0, k[0]});
      repeat (k ? 3 : 7) tick();
      rc(IDX_INT_CTRL, 32'h0);
      tick();
      rc(IDX_INT_CTRL, 32'h1);
      wr(IDX_INT_CTRL, 8'h00);
    end
    wr(IDX_IEN_HIGH, 8'h80);
    wr(IDX_IEN_LOW, 8'h80);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_MISC, k ? 8'h80 : 8'h00);
      repeat (120) @(posedge hclk);
      rc(IDX_IRQ_FLAGS, k ? 32'h80 : 32'h0);
      cmp({31'h0, wake_req}, {31'h0, k[0]});
    end
    wr(IDX_MISC, 8'h00);
    v = $random(seed);
    pin_level <= v[12:8];
    wr(IDX_PIN_POL, v[7:0]);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rc(IDX_IRQ_FLAGS, {27'h0, ~(v[12:8] ^ v[4:0])});
    pin_level <= ~v[4:0];
    repeat (3) @(posedge hclk);
    rc(IDX_IRQ_FLAGS, {27'h0, ~(v[12:8] ^ v[4:0])});
    timebase_evt <= 1'b1;
    @(posedge hclk);
    timebase_evt <= 1'b0;
    rc(IDX_IRQ_FLAGS, {24'h0, 3'h1, ~(v[12:8] ^ v[4:0])});
    wr(IDX_INT_CTRL, 8'h02);
    wr(IDX_WAKE_DIS, 8'hFF);
    repeat (2) @(posedge hclk);
    cmp({31'h0, wake_req}, 32'h0);
    wr(IDX_WAKE_DIS, 8'hDF);
    repeat (2) @(posedge hclk);
    cmp({31'h0, wake_req}, 32'h1);
    wrap_up();
  end
endmodule : dsp_mcu_mailbox_irq_tb
`default_nettype wire

// file: pkg/dmb_if.sv
// Link between the microcontroller end and the coprocessor end
`timescale 1ns/1ns
`default_nettype none
interface dmb_if;
  logic        m2d_tog;
  logic [7:0]  m2d_ctrl;
  logic [15:0] m2d_data;
  logic        m2d_ack;
  logic        d2m_tog;
  logic [7:0]  d2m_ctrl;
  logic [15:0] d2m_data;
  logic        d2m_ack;
  modport micro_end   (output m2d_tog, m2d_ctrl, m2d_data, d2m_ack, input m2d_ack, d2m_tog, d2m_ctrl, d2m_data);
  modport coproc_end  (input m2d_tog, m2d_ctrl, m2d_data, d2m_ack, output m2d_ack, d2m_tog, d2m_ctrl, d2m_data);
endinterface : dmb_if
`default_nettype wire

// file: pkg/dmb_pkg.sv
// Package for the microcontroller/coprocessor mailbox and interrupt block
// Functional notes
// (RL1) Enable-low: master bit 7, seven source enables
// (RL2) Enable-high: minute, message, bus, pins 6-2
// (RL3) Request flags: minute, message, timebase, pins 6-2
// (RL4) Hardware sets flags; only software clears
// (RL5) Polarity bits pick pin active level
// (RL6) Control: frame-sync flag bit0, extended wake bit1
// (RL7) Wake-disable bit per flagged source
// (RL8) Six byte registers, four coprocessor registers
// (RL9) Handshakes deliver whole old or new sets
// (RL10) Coprocessor reads control before data
// (RL11) Coprocessor request raises message interrupt
// (RL12) First outbound write copies all three bytes
// (RL13) Outbound set held while coprocessor off
// (RL14) Micro waits 125 us between outbound writes
// (RL15) Coprocessor control write latches inbound, interrupts
// (RL16) At most one trigger per direction per 125 us
// (RL17) Frame-sync at tick/8, switchable to tick/4
// (RL18) Minute interrupt when enabled and clock normal
// (RL19) Minute service routine clears its flag
// (RL20) Minute interrupt wakes from power-down and idle
// (RL21) Master enable off suppresses all sources; code gates irq_req, but extended wake still raises wake_req
// (RL22) Flags captured on always-running clock
// (RL23) Toggles pass two flip-flops before use
package dmb_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_IEN_LOW   = 8'hA8;
  localparam logic [7:0]  IDX_WAKE_DIS  = 8'hB9;
  localparam logic [7:0]  IDX_IRQ_FLAGS = 8'hC0;
  localparam logic [7:0]  IDX_INT_CTRL  = 8'hC1;
  localparam logic [7:0]  IDX_IEN_HIGH  = 8'hE8;
  localparam logic [7:0]  IDX_PIN_POL   = 8'hE9;
  localparam logic [7:0]  IDX_OUT_B0    = 8'h10;
  localparam logic [7:0]  IDX_OUT_B1    = 8'h11;
  localparam logic [7:0]  IDX_OUT_B2    = 8'h12;
  localparam logic [7:0]  IDX_IN_B0     = 8'h13;
  localparam logic [7:0]  IDX_IN_B1     = 8'h14;
  localparam logic [7:0]  IDX_IN_B2     = 8'h15;
  localparam logic [7:0]  IDX_MISC      = 8'h16;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  // Field positions
  localparam int          B_GLOBAL      = 7;
  localparam int          B_RTC         = 7;
  localparam int          B_DSP         = 6;
  localparam int          B_TIME        = 5;
  localparam int          B_FS_FLAG     = 0;
  localparam int          B_XWU         = 1;
  localparam int          B_FS_FAST     = 0;
  localparam int          B_CLK_NORMAL  = 7;
  localparam int          B_TX_BUSY     = 4;
  // Coprocessor I/O register addresses
  localparam logic [1:0]  IO_IN_CTRL    = 2'h0;
  localparam logic [1:0]  IO_IN_DATA    = 2'h1;
  localparam logic [1:0]  IO_OUT_CTRL   = 2'h2;
  localparam logic [1:0]  IO_OUT_DATA   = 2'h3;
  // Timing
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          MINUTE_S      = 60;
  localparam longint      MINUTE_CYC    = longint'(CLK_HZ) * MINUTE_S;
  localparam logic [2:0]  FS_DIV_SLOW   = 3'h7;
  localparam logic [2:0]  FS_DIV_FAST   = 3'h3;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_PEND} dmb_tx_t;
  typedef enum logic       {RX_IDLE, RX_CTRL_READ} dmb_rx_t;
endpackage : dmb_pkg

// file: rtl/dmb_coproc.sv
// Coprocessor end: four I/O registers and both handshake machines
`timescale 1ns/1ns
`default_nettype none
module dmb_coproc (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  dmb_if.coproc_end   lnk,
  input  wire logic   dsp_on,
  input  wire logic [1:0]  io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_wdata,
  output logic [15:0]      io_rdata
);
  import dmb_pkg::*;
  logic           rx_pulse, ack_pulse;
  logic           pend_r, pend_nxt, mack_r, mack_nxt, tog_r, tog_nxt;
  dmb_rx_t        rx_r, rx_nxt;
  dmb_tx_t        tx_r, tx_nxt;
  logic [7:0]     in_ctrl_r, in_ctrl_nxt, out_ctrl_r, out_ctrl_nxt, hc_r, hc_nxt;
  logic [15:0]    in_data_r, in_data_nxt, out_data_r, out_data_nxt, hd_r, hd_nxt, rd_r, rd_nxt;

  dmb_tsync u_rx (.hclk(hclk), .hresetn(hresetn), .tog(lnk.m2d_tog), .pulse(rx_pulse));
  dmb_tsync u_ack (.hclk(hclk), .hresetn(hresetn), .tog(lnk.d2m_ack), .pulse(ack_pulse));

  always_comb begin
    pend_nxt = pend_r | rx_pulse;
    mack_nxt = mack_r;
    rx_nxt = rx_r;
    in_ctrl_nxt = in_ctrl_r;
    in_data_nxt = in_data_r;
    out_ctrl_nxt = out_ctrl_r;
    out_data_nxt = out_data_r;
    tx_nxt = tx_r;
    tog_nxt = tog_r;
    hc_nxt = hc_r;
    hd_nxt = hd_r;
    rd_nxt = rd_r;
    // Load a new set only when powered and no half-read pair [RL9] [RL13]
    // A control read in this cycle pairs with the data still held
    if (pend_r && dsp_on && rx_r == RX_IDLE && !(io_rd && io_addr == IO_IN_CTRL)) begin
      in_ctrl_nxt = lnk.m2d_ctrl;
      in_data_nxt = lnk.m2d_data;
      pend_nxt = rx_pulse;
      mack_nxt = ~mack_r;
    end
    if (io_rd) begin
      case (io_addr)
        IO_IN_CTRL: begin
          rd_nxt = {8'h00, in_ctrl_r}; // [RL12]
          rx_nxt = RX_CTRL_READ; // [RL10]
        end
        IO_IN_DATA: begin
          rd_nxt = in_data_r;
          rx_nxt = RX_IDLE; // [RL10]
        end
        IO_OUT_CTRL: rd_nxt = {8'h00, out_ctrl_r};
        default: rd_nxt = out_data_r;
      endcase
    end
    if (io_wr && io_addr == IO_OUT_DATA) begin
      out_data_nxt = io_wdata;
    end
    case (tx_r)
      TX_IDLE: begin
        if (io_wr && io_addr == IO_OUT_CTRL) begin
          out_ctrl_nxt = io_wdata[7:0];
          hc_nxt = io_wdata[7:0]; // [RL15]
          hd_nxt = out_data_nxt;
          tog_nxt = ~tog_r; // [RL11]
          tx_nxt = TX_WAIT;
        end
      end
      TX_WAIT, TX_PEND: begin
        if (io_wr && io_addr == IO_OUT_CTRL) begin
          out_ctrl_nxt = io_wdata[7:0];
          tx_nxt = TX_PEND;
        end
        if (ack_pulse) begin
          if (tx_nxt == TX_PEND) begin
            hc_nxt = out_ctrl_nxt;
            hd_nxt = out_data_nxt;
            tog_nxt = ~tog_r; // [RL9]
            tx_nxt = TX_WAIT;
          end else begin
            tx_nxt = TX_IDLE;
          end
        end
      end
      default: tx_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      mack_r <= 1'b0;
      tog_r <= 1'b0;
      rx_r <= RX_IDLE;
      tx_r <= TX_IDLE;
      in_ctrl_r <= 8'h00;
      out_ctrl_r <= 8'h00;
      hc_r <= 8'h00;
      in_data_r <= 16'h0000;
      out_data_r <= 16'h0000;
      hd_r <= 16'h0000;
      rd_r <= 16'h0000;
    end else begin
      pend_r <= pend_nxt;
      mack_r <= mack_nxt;
      tog_r <= tog_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      in_ctrl_r <= in_ctrl_nxt;
      out_ctrl_r <= out_ctrl_nxt;
      hc_r <= hc_nxt;
      in_data_r <= in_data_nxt;
      out_data_r <= out_data_nxt;
      hd_r <= hd_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign lnk.m2d_ack = mack_r;
  assign lnk.d2m_tog = tog_r;
  assign lnk.d2m_ctrl = hc_r;
  assign lnk.d2m_data = hd_r;
  assign io_rdata = rd_r;
endmodule : dmb_coproc
`default_nettype wire

// file: rtl/dmb_micro.sv
// Microcontroller end: AHB-Lite registers, interrupt flags and mailbox bytes
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dmb_micro #(
  parameter longint MINUTE_CYCLES = dmb_pkg::MINUTE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  dmb_if.micro_end         lnk,
  input  wire logic [4:0]  pin_level,
  input  wire logic [4:0]  src_pend,
  input  wire logic        i2c_pend,
  input  wire logic        timebase_evt,
  input  wire logic        sample_frame_tick,
  output logic             irq_req,
  output logic             wake_req
);
  import dmb_pkg::*;
  logic           msg_pulse, ack_pulse;
  logic [7:0]     interrupt_enable_low_r, interrupt_enable_low_nxt, interrupt_enable_high_r, interrupt_enable_high_nxt, flg_r, flg_nxt, pol_r, pol_nxt;
  logic [7:0]     ictl_r, ictl_nxt, wakeup_disable_r, wakeup_disable_nxt, misc_r, misc_nxt;
  logic [7:0]     ob_r [3];
  logic [7:0]     ob_nxt [3];
  logic [7:0]     ib_r [3];
  logic [7:0]     ib_nxt [3];
  logic [7:0]     hc_r, hc_nxt;
  logic [15:0]    hd_r, hd_nxt;
  logic           tog_r, tog_nxt, dack_r, dack_nxt;
  dmb_tx_t        tx_r, tx_nxt;
  logic [2:0]     fs_r, fs_nxt;
  logic [63:0]    min_r, min_nxt;
  logic [7:0]     idx_r, idx_nxt;
  logic           ph_r, ph_nxt, wr_r, wr_nxt, rdy_r, rdy_nxt, irq_r, irq_nxt, wk_r, wk_nxt;
  logic [31:0]    rd_r, rd_nxt;
  logic [7:0]     rsel, set1;
  logic [4:0]     pin_act;
  logic           fs_evt, min_evt, wbyte0;

  dmb_tsync u_msg (.hclk(hclk), .hresetn(hresetn), .tog(lnk.d2m_tog), .pulse(msg_pulse));
  dmb_tsync u_ack (.hclk(hclk), .hresetn(hresetn), .tog(lnk.m2d_ack), .pulse(ack_pulse));

  always_comb begin
    case (idx_r)
      IDX_IEN_LOW:   rsel = interrupt_enable_low_r;
      IDX_IEN_HIGH:  rsel = interrupt_enable_high_r;
      IDX_IRQ_FLAGS: rsel = flg_r;
      IDX_PIN_POL:   rsel = pol_r;
      IDX_INT_CTRL:  rsel = ictl_r;
      IDX_WAKE_DIS:  rsel = wakeup_disable_r;
      IDX_OUT_B0:    rsel = ob_r[0]; // [RL8]
      IDX_OUT_B1:    rsel = ob_r[1];
      IDX_OUT_B2:    rsel = ob_r[2];
      IDX_IN_B0:     rsel = ib_r[0];
      IDX_IN_B1:     rsel = ib_r[1];
      IDX_IN_B2:     rsel = ib_r[2];
      IDX_MISC:      rsel = {misc_r[7:5], (tx_r != TX_IDLE), misc_r[3:0]};
      default:       rsel = 8'h00;
    endcase
  end

  always_comb begin
    interrupt_enable_low_nxt = interrupt_enable_low_r;
    interrupt_enable_high_nxt = interrupt_enable_high_r;
    pol_nxt = pol_r;
    wakeup_disable_nxt = wakeup_disable_r;
    misc_nxt = misc_r;
    ob_nxt = ob_r;
    ib_nxt = ib_r;
    flg_nxt = flg_r;
    ictl_nxt = ictl_r;
    hc_nxt = hc_r;
    hd_nxt = hd_r;
    tog_nxt = tog_r;
    dack_nxt = dack_r;
    tx_nxt = tx_r;
    idx_nxt = idx_r;
    wr_nxt = 1'b0;
    ph_nxt = 1'b0;
    rdy_nxt = 1'b1;
    rd_nxt = rd_r;
    wbyte0 = 1'b0;
    // Bus: take address phase, then one wait cycle before the answer
    if (hsel && htrans[1] && hready) begin
      idx_nxt = haddr[9:2];
      wr_nxt = hwrite;
      ph_nxt = 1'b1;
      rdy_nxt = 1'b0;
    end
    if (ph_r && !wr_r) begin
      rd_nxt = {24'h000000, rsel};
    end
    if (ph_r && wr_r) begin
      case (idx_r)
        IDX_IEN_LOW:   interrupt_enable_low_nxt = hwdata[7:0]; // [RL1]
        IDX_IEN_HIGH:  interrupt_enable_high_nxt = hwdata[7:0]; // [RL2]
        IDX_IRQ_FLAGS: flg_nxt = hwdata[7:0]; // [RL3] [RL19]
        IDX_PIN_POL:   pol_nxt = hwdata[7:0]; // [RL5]
        IDX_INT_CTRL:  ictl_nxt = {6'h00, hwdata[1:0]}; // [RL6]
        IDX_WAKE_DIS:  wakeup_disable_nxt = hwdata[7:0]; // [RL7]
        IDX_OUT_B0: begin
          ob_nxt[0] = hwdata[7:0];
          wbyte0 = 1'b1;
        end
        IDX_OUT_B1:    ob_nxt[1] = hwdata[7:0];
        IDX_OUT_B2:    ob_nxt[2] = hwdata[7:0];
        IDX_MISC:      misc_nxt = {hwdata[7], 6'h00, hwdata[0]};
        default: ;
      endcase
    end
    // Event sources; a set in the same cycle as a clear wins [RL4] [RL22]
    pin_act = ~(pin_level ^ pol_r[4:0]); // [RL5]
    fs_evt = sample_frame_tick && (fs_r == (misc_r[B_FS_FAST] ? FS_DIV_FAST : FS_DIV_SLOW)); // [RL17]
    min_evt = (min_r == MINUTE_CYCLES - 1);
    set1 = {min_evt && interrupt_enable_low_r[B_GLOBAL] && interrupt_enable_high_r[B_RTC] && misc_r[B_CLK_NORMAL], // [RL18]
            msg_pulse, timebase_evt, pin_act}; // [RL11]
    flg_nxt = flg_nxt | set1; // [RL4]
    ictl_nxt[B_FS_FLAG] = ictl_nxt[B_FS_FLAG] | fs_evt;
    fs_nxt = sample_frame_tick ? (fs_evt ? 3'h0 : fs_r + 3'h1) : fs_r;
    min_nxt = min_evt ? 64'h0 : min_r + 64'h1;
    // Inbound set latched on the coprocessor's control write [RL15]
    if (msg_pulse) begin
      ib_nxt[0] = lnk.d2m_ctrl;
      ib_nxt[1] = lnk.d2m_data[15:8];
      ib_nxt[2] = lnk.d2m_data[7:0];
      dack_nxt = ~dack_r;
    end
    // Outbound transmit machine [RL9] [RL12] [RL13]
    case (tx_r)
      TX_IDLE: begin
        if (wbyte0) begin
          hc_nxt = ob_nxt[0];
          hd_nxt = {ob_r[1], ob_r[2]};
          tog_nxt = ~tog_r;
          tx_nxt = TX_WAIT;
        end
      end
      TX_WAIT, TX_PEND: begin
        if (wbyte0) begin
          tx_nxt = TX_PEND;
        end
        if (ack_pulse) begin
          if (tx_nxt == TX_PEND) begin
            hc_nxt = ob_nxt[0];
            hd_nxt = {ob_nxt[1], ob_nxt[2]};
            tog_nxt = ~tog_r;
            tx_nxt = TX_WAIT;
          end else begin
            tx_nxt = TX_IDLE;
          end
        end
      end
      default: tx_nxt = TX_IDLE;
    endcase
    // Master enable gates every source [RL21]
    irq_nxt = interrupt_enable_low_r[B_GLOBAL] && ((|(interrupt_enable_low_r[6:0] & {ictl_r[B_FS_FLAG], flg_r[B_TIME], src_pend}))
              || (|(interrupt_enable_high_r & {flg_r[7:6], i2c_pend, flg_r[4:0]})));
    // Minute flag always wakes; others through extended wake-up [RL20] [RL7]
    wk_nxt = flg_r[B_RTC] || (ictl_r[B_XWU] && (|(flg_r[6:0] & ~wakeup_disable_r[6:0])));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_enable_low_r <= RST_BYTE;
      interrupt_enable_high_r <= RST_BYTE;
      flg_r <= RST_BYTE;
      pol_r <= RST_BYTE;
      ictl_r <= RST_BYTE;
      wakeup_disable_r <= RST_BYTE;
      misc_r <= RST_BYTE;
      ob_r <= '{default: 8'h00};
      ib_r <= '{default: 8'h00};
      hc_r <= 8'h00;
      hd_r <= 16'h0000;
      tog_r <= 1'b0;
      dack_r <= 1'b0;
      tx_r <= TX_IDLE;
      fs_r <= 3'h0;
      min_r <= 64'h0;
      idx_r <= 8'h00;
      ph_r <= 1'b0;
      wr_r <= 1'b0;
      rdy_r <= 1'b1;
      rd_r <= 32'h00000000;
      irq_r <= 1'b0;
      wk_r <= 1'b0;
    end else begin
      interrupt_enable_low_r <= interrupt_enable_low_nxt;
      interrupt_enable_high_r <= interrupt_enable_high_nxt;
      flg_r <= flg_nxt;
      pol_r <= {3'h0, pol_nxt[4:0]};
      ictl_r <= ictl_nxt;
      wakeup_disable_r <= wakeup_disable_nxt;
      misc_r <= misc_nxt;
      ob_r <= ob_nxt;
      ib_r <= ib_nxt;
      hc_r <= hc_nxt;
      hd_r <= hd_nxt;
      tog_r <= tog_nxt;
      dack_r <= dack_nxt;
      tx_r <= tx_nxt;
      fs_r <= fs_nxt;
      min_r <= min_nxt;
      idx_r <= idx_nxt;
      ph_r <= ph_nxt;
      wr_r <= wr_nxt;
      rdy_r <= rdy_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
      wk_r <= wk_nxt;
    end
  end

  assign hrdata = rd_r;
  assign hreadyout = rdy_r;
  assign hresp = 1'b0;
  assign irq_req = irq_r;
  assign wake_req = wk_r;
  assign lnk.m2d_tog = tog_r;
  assign lnk.m2d_ctrl = hc_r;
  assign lnk.m2d_data = hd_r;
  assign lnk.d2m_ack = dack_r;
endmodule : dmb_micro
`default_nettype wire

// file: rtl/dmb_tsync.sv
// Toggle synchroniser producing a one-cycle pulse per toggle
`timescale 1ns/1ns
`default_nettype none
module dmb_tsync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tog,
  output logic      pulse
);
  logic [2:0] sr_r;
  logic [2:0] sr_nxt;
  always_comb begin
    sr_nxt = {sr_r[1:0], tog};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_r <= 3'h0;
    end else begin
      sr_r <= sr_nxt;
    end
  end
  // Edge taken between second and third stage [RL23]
  assign pulse = sr_r[1] ^ sr_r[2];
endmodule : dmb_tsync
`default_nettype wire
